//--- hw/lts_pkg.sv
package lts_pkg;

	// Clock rate, used to turn times into cycle counts
	localparam int unsigned CLK_MHZ = 100;

	// Hard-wired decision points in burst counts
	localparam int unsigned LOWER_LEVEL_THRESHOLD = 250;
	localparam int unsigned UPPER_LEVEL_THRESHOLD = 150;
	localparam int unsigned HYST_COUNTS = 3;

	// Nominal slosh filter reaction time and burst repetition period
	localparam int unsigned SLOSH_TIME_MS = 15000;
	localparam int unsigned BURST_PERIOD_MS = 100;
	localparam int unsigned INTEG_LIMIT = SLOSH_TIME_MS / BURST_PERIOD_MS;

	// Health window before each burst, all pins released
	localparam int unsigned HEALTH_US = 350;
	localparam int unsigned HEALTH_CYC = HEALTH_US * CLK_MHZ;

	// Idle gap between the end of one burst and the next health window
	localparam int unsigned BURST_GAP_CYC = BURST_PERIOD_MS * 1000 * CLK_MHZ;

	// Average duration of one acquisition count, in ns
	localparam int unsigned COUNT_NS = 7000;
	localparam int unsigned COUNT_RANGE = 1024;
	localparam int unsigned BURST_MAX_CYC = (COUNT_RANGE * COUNT_NS) / (1000 / CLK_MHZ);

	// Register byte offsets
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_STATUS = 4'h4;
	localparam logic [3:0] REG_COUNT = 4'h8;
	localparam logic [3:0] REG_INTEG = 4'hC;

	// Field positions and reset values
	localparam int unsigned CTRL_RUN_BIT = 0;
	localparam logic CTRL_RUN_RST = 1'b1;
	localparam int unsigned ST_LOW_DET_BIT = 0;
	localparam int unsigned ST_HIGH_DET_BIT = 1;
	localparam int unsigned ST_LOW_ACT_BIT = 2;
	localparam int unsigned ST_HIGH_ACT_BIT = 3;
	localparam int unsigned ST_FILTER_BIT = 4;
	localparam int unsigned ST_POLARITY_BIT = 5;
	localparam int unsigned ST_HEALTH_BIT = 6;
	localparam int unsigned ST_TIMEOUT_BIT = 7;

	// AXI responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Measurement sequencer states
	typedef enum logic [1:0] {
		SEQ_GAP,
		SEQ_HEALTH,
		SEQ_BURST
	} lts_seq_t;

endpackage

//--- hw/lts_integrator.sv
`timescale 1ns/1ns

module lts_integrator #(
	parameter int unsigned INTEG_W = 16,
	parameter int unsigned LIMIT = lts_pkg::INTEG_LIMIT
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Decision input, one step per finished burst
	input wire logic step,
	input wire logic detect,
	input wire logic filterEn,
	// Filtered result
	output logic active,
	output logic [INTEG_W-1:0] count
);
	import lts_pkg::*;

	localparam logic [INTEG_W-1:0] LIM = INTEG_W'(LIMIT);

	logic [INTEG_W-1:0] cnt_r;
	logic [INTEG_W-1:0] cnt_nxt;
	logic held_r;
	logic held_nxt;
	logic atLimit;
	logic atZero;

	assign atLimit = (cnt_r >= LIM);
	assign atZero = (cnt_r == '0);

	// Saturating up/down count, moved only once per burst
	always_comb begin
		cnt_nxt = cnt_r;
		if (step && detect && !atLimit) begin
			cnt_nxt = cnt_r + INTEG_W'(1); // RULE1 RULE18
		end else if (step && !detect && !atZero) begin
			cnt_nxt = cnt_r - INTEG_W'(1); // RULE2 RULE18
		end
	end

	// Latch on at the limit, release only at zero; no timeout while held
	assign held_nxt = atLimit ? 1'b1 : (atZero ? 1'b0 : held_r); // RULE1 RULE3 RULE17

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r <= '0;
			held_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			held_r <= held_nxt;
		end
	end

	// Counter keeps running when bypassed so a later enable starts from real history
	assign active = filterEn ? held_r : detect; // RULE6
	assign count = cnt_r;

endmodule

//--- hw/lts_level_threshold.sv
`timescale 1ns/1ns

// What this block does
// RULE1: Count up per detection; activate at limit.
// RULE2: Count down per non-detecting burst.
// RULE3: Active output stays until counter zero.
// RULE4: Limit sized for nominal fifteen-second reaction.
// RULE5: Separate counters for low and high outputs.
// RULE6: One strap enables or bypasses both filters.
// RULE7: Filter strap sampled continuously, live changes.
// RULE8: Fixed thresholds: lower 250, upper 150.
// RULE9: Count below threshold means detection.
// RULE10: Three-count hysteresis around each threshold.
// RULE11: One count lasts about seven microseconds.
// RULE12: Decisions use integer burst count only.
// RULE13: Threshold spread fixed, no adjustment input.
// RULE14: Single-point users read low output only.
// RULE15: Polarity strap selects active-low or active-high.
// RULE16: Both outputs released before every burst.
// RULE17: No timeout on an active output.
// RULE18: Integration counters saturate at zero and limit.

module lts_level_threshold #(
	parameter int unsigned COUNT_W = 10,
	parameter int unsigned INTEG_W = 16,
	parameter int unsigned INTEG_LIMIT = lts_pkg::INTEG_LIMIT,
	parameter int unsigned HEALTH_CYC = lts_pkg::HEALTH_CYC,
	parameter int unsigned BURST_GAP_CYC = lts_pkg::BURST_GAP_CYC,
	parameter int unsigned BURST_MAX_CYC = lts_pkg::BURST_MAX_CYC
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Acquisition front end
	output logic burstReq,
	input wire logic burstDone,
	input wire logic [COUNT_W-1:0] burstCount,
	// Straps
	input wire logic slosh_filter_strap,
	input wire logic output_polarity_strap,
	// Limit output pins
	output logic low_limit_output,
	output logic lowLimitOe,
	output logic high_limit_output,
	output logic highLimitOe,
	// AXI4-Lite write address
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [3:0] s_axi_awaddr,
	// AXI4-Lite write data
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	// AXI4-Lite write response
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	// AXI4-Lite read address
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [3:0] s_axi_araddr,
	// AXI4-Lite read data
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp
);
	import lts_pkg::*;

	// Thresholds are fixed constants, so the spread between them is too
	localparam logic [COUNT_W-1:0] LOW_TH = COUNT_W'(LOWER_LEVEL_THRESHOLD); // RULE8 RULE13
	localparam logic [COUNT_W-1:0] HIGH_TH = COUNT_W'(UPPER_LEVEL_THRESHOLD); // RULE8 RULE13
	localparam logic [COUNT_W-1:0] HYST = COUNT_W'(HYST_COUNTS);

	// Strap sampling
	logic filterStrap_r;
	logic polarityStrap_r;
	// Re-read every clock so strap changes act without any restart
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			filterStrap_r <= 1'b0;
			polarityStrap_r <= 1'b0;
		end else begin
			filterStrap_r <= slosh_filter_strap; // RULE7
			polarityStrap_r <= output_polarity_strap;
		end
	end

	// Measurement sequencer: gap, health window, burst
	lts_seq_t seq_r;
	lts_seq_t seq_nxt;
	logic [31:0] timer_r;
	logic [31:0] timer_nxt;
	logic run_r;
	logic gapDone;
	logic healthDone;
	logic burstTimeout;
	logic burstTaken;
	logic timeout_r;

	assign gapDone = (timer_r >= 32'(BURST_GAP_CYC - 1));
	assign healthDone = (timer_r >= 32'(HEALTH_CYC - 1));
	// Longest legal burst is the full count range at the per-count time
	assign burstTimeout = (timer_r >= 32'(BURST_MAX_CYC - 1)); // RULE11
	assign burstTaken = (seq_r == SEQ_BURST) && burstDone;

	// Next state and timer
	always_comb begin
		seq_nxt = seq_r;
		timer_nxt = timer_r + 32'h00000001;
		unique case (seq_r)
			SEQ_GAP: begin
				if (!run_r) begin
					timer_nxt = 32'h00000000;
				end else if (gapDone) begin
					seq_nxt = SEQ_HEALTH;
					timer_nxt = 32'h00000000;
				end
			end
			SEQ_HEALTH: begin
				if (healthDone) begin
					seq_nxt = SEQ_BURST; // RULE16
					timer_nxt = 32'h00000000;
				end
			end
			SEQ_BURST: begin
				if (burstDone || burstTimeout) begin
					seq_nxt = SEQ_GAP;
					timer_nxt = 32'h00000000;
				end
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			seq_r <= SEQ_GAP;
			timer_r <= 32'h00000000;
		end else begin
			seq_r <= seq_nxt;
			timer_r <= timer_nxt;
		end
	end

	// Burst request is a single pulse on leaving the health window
	assign burstReq = (seq_r == SEQ_HEALTH) && healthDone;

	// Sticky note that a burst never finished; cleared by the next good one
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			timeout_r <= 1'b0;
		end else if (seq_r == SEQ_BURST && burstTimeout && !burstDone) begin
			timeout_r <= 1'b1;
		end else if (burstTaken) begin
			timeout_r <= 1'b0;
		end
	end

	// Threshold decisions with hysteresis
	logic [COUNT_W-1:0] lastCount_r;
	logic lowDet_r;
	logic highDet_r;
	logic lowDet_nxt;
	logic highDet_nxt;

	// Lower count means more electrode load, so below the point is a detection.
	// Set below the point, clear only once at or above point plus hysteresis.
	assign lowDet_nxt = lowDet_r ? (burstCount < LOW_TH + HYST) : (burstCount < LOW_TH); // RULE9 RULE10 RULE12
	assign highDet_nxt = highDet_r ? (burstCount < HIGH_TH + HYST) : (burstCount < HIGH_TH); // RULE9 RULE10 RULE12

	// Decisions change only on a finished burst, never on time
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			lastCount_r <= '0;
			lowDet_r <= 1'b0;
			highDet_r <= 1'b0;
		end else if (burstTaken) begin
			lastCount_r <= burstCount;
			lowDet_r <= lowDet_nxt;
			highDet_r <= highDet_nxt;
		end
	end

	// Integrators step one cycle after the decision register updates
	logic step_r;
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			step_r <= 1'b0;
		end else begin
			step_r <= burstTaken;
		end
	end

	// Independent slosh filters, one per output
	logic lowActive;
	logic highActive;
	logic [INTEG_W-1:0] lowInteg;
	logic [INTEG_W-1:0] highInteg;

	// Limit in bursts sets the nominal reaction time at the burst period
	lts_integrator #(
		.INTEG_W(INTEG_W),
		.LIMIT(INTEG_LIMIT) // RULE4
	) u_lowFilter (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.step(step_r),
		.detect(lowDet_r),
		.filterEn(filterStrap_r), // RULE6
		.active(lowActive),
		.count(lowInteg)
	); // RULE5

	lts_integrator #(
		.INTEG_W(INTEG_W),
		.LIMIT(INTEG_LIMIT) // RULE4
	) u_highFilter (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.step(step_r),
		.detect(highDet_r),
		.filterEn(filterStrap_r), // RULE6
		.active(highActive),
		.count(highInteg)
	); // RULE5

	// Output pins: polarity and health window
	logic lowPin_r;
	logic highPin_r;
	logic pinOe_r;

	// Pins are registered so strap or decision changes never glitch them
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			lowPin_r <= 1'b0;
			highPin_r <= 1'b0;
			pinOe_r <= 1'b0;
		end else begin
			lowPin_r <= polarityStrap_r ? lowActive : !lowActive; // RULE15
			highPin_r <= polarityStrap_r ? highActive : !highActive; // RULE15
			pinOe_r <= (seq_nxt != SEQ_HEALTH); // RULE16
		end
	end

	assign low_limit_output = lowPin_r;
	assign high_limit_output = highPin_r;
	assign lowLimitOe = pinOe_r;
	assign highLimitOe = pinOe_r;

	// AXI4-Lite write path
	logic awHeld_r;
	logic wHeld_r;
	logic [3:0] awAddr_r;
	logic [31:0] wData_r;
	logic [3:0] wStrb_r;
	logic bValid_r;
	logic [1:0] bResp_r;
	logic awFire;
	logic wFire;
	logic doWrite;
	logic wrCtrl;

	// Address and data may arrive in either order; each is held until both are here
	assign s_axi_awready = !awHeld_r && !bValid_r;
	assign s_axi_wready = !wHeld_r && !bValid_r;
	assign awFire = s_axi_awvalid && s_axi_awready;
	assign wFire = s_axi_wvalid && s_axi_wready;
	assign doWrite = awHeld_r && wHeld_r && !bValid_r;
	assign wrCtrl = doWrite && (awAddr_r == REG_CTRL);

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			awHeld_r <= 1'b0;
			wHeld_r <= 1'b0;
			awAddr_r <= 4'h0;
			wData_r <= 32'h00000000;
			wStrb_r <= 4'h0;
		end else begin
			if (awFire) begin
				awHeld_r <= 1'b1;
				awAddr_r <= s_axi_awaddr;
			end else if (doWrite) begin
				awHeld_r <= 1'b0;
			end
			if (wFire) begin
				wHeld_r <= 1'b1;
				wData_r <= s_axi_wdata;
				wStrb_r <= s_axi_wstrb;
			end else if (doWrite) begin
				wHeld_r <= 1'b0;
			end
		end
	end

	// Response: only the control word is writable, everything else errors
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			bValid_r <= 1'b0;
			bResp_r <= RESP_OKAY;
		end else if (doWrite) begin
			bValid_r <= 1'b1;
			bResp_r <= (awAddr_r == REG_CTRL) ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			bValid_r <= 1'b0;
		end
	end

	assign s_axi_bvalid = bValid_r;
	assign s_axi_bresp = bResp_r;

	// Run bit gates new bursts; an ongoing burst always completes
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			run_r <= CTRL_RUN_RST;
		end else if (wrCtrl && wStrb_r[0]) begin
			run_r <= wData_r[CTRL_RUN_BIT];
		end
	end

	// AXI4-Lite read path
	logic rValid_r;
	logic [31:0] rData_r;
	logic [1:0] rResp_r;
	logic arFire;
	logic [31:0] statusWord;
	logic [31:0] ctrlWord;
	logic [31:0] countWord;
	logic [31:0] integWord;
	logic [31:0] rdMux;
	logic rdHit;

	assign s_axi_arready = !rValid_r;
	assign arFire = s_axi_arvalid && s_axi_arready;

	// Read words; unused bits read as zero
	assign ctrlWord = {31'h00000000, run_r};
	assign statusWord = {24'h000000, timeout_r, !pinOe_r, polarityStrap_r, filterStrap_r,
		highActive, lowActive, highDet_r, lowDet_r};
	assign countWord = 32'(lastCount_r);
	assign integWord = {16'(highInteg), 16'(lowInteg)};

	assign rdHit = (s_axi_araddr == REG_CTRL) || (s_axi_araddr == REG_STATUS) ||
		(s_axi_araddr == REG_COUNT) || (s_axi_araddr == REG_INTEG);
	assign rdMux = (s_axi_araddr == REG_CTRL) ? ctrlWord :
		(s_axi_araddr == REG_STATUS) ? statusWord :
		(s_axi_araddr == REG_COUNT) ? countWord :
		(s_axi_araddr == REG_INTEG) ? integWord : 32'h00000000;

	// Data is captured at the address handshake and held until taken
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rValid_r <= 1'b0;
			rData_r <= 32'h00000000;
			rResp_r <= RESP_OKAY;
		end else if (arFire) begin
			rValid_r <= 1'b1;
			rData_r <= rdMux;
			rResp_r <= rdHit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rready) begin
			rValid_r <= 1'b0;
		end
	end

	assign s_axi_rvalid = rValid_r;
	assign s_axi_rdata = rData_r;
	assign s_axi_rresp = rResp_r;

endmodule

//--- verif/lts_level_threshold_chk.sv
`timescale 1ns/1ns

module lts_level_threshold_chk #(
	parameter int unsigned HEALTH_CYC = 8
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Front end and straps
	input wire logic burstReq,
	input wire logic burstDone,
	input wire logic [9:0] burstCount,
	input wire logic slosh_filter_strap,
	input wire logic output_polarity_strap,
	// Limit pins
	input wire logic low_limit_output,
	input wire logic lowLimitOe,
	input wire logic high_limit_output,
	input wire logic highLimitOe,
	// Register bus
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [3:0] s_axi_awaddr,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata
);
	import lts_pkg::*;
	logic [15:0] oeLowCnt_r;
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);

	// Counts released cycles so the window length can be judged at the burst request
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			oeLowCnt_r <= 16'h0000;
		else if (lowLimitOe)
			oeLowCnt_r <= 16'h0000;
		else
			oeLowCnt_r <= oeLowCnt_r + 16'h0001;
	end

	// Both straps held so the pin reflects only the decision
	sequence s_bypassHold;
		(!slosh_filter_strap && $stable(output_polarity_strap))[*4];
	endsequence
	sequence s_wrBoth;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence

	property p_healthLen;
		burstReq |-> !lowLimitOe && oeLowCnt_r == 16'(HEALTH_CYC - 1);
	endproperty
	a_healthLen: assert property (p_healthLen) else $error("release window length wrong");
	property p_oeBack;
		burstReq |=> lowLimitOe && highLimitOe;
	endproperty
	a_oeBack: assert property (p_oeBack) else $error("pins not driven at burst start");
	property p_oePair;
		lowLimitOe == highLimitOe;
	endproperty
	a_oePair: assert property (p_oePair) else $error("pin enables differ");
	property p_reqPulse;
		burstReq |=> !burstReq;
	endproperty
	a_reqPulse: assert property (p_reqPulse) else $error("burst request longer than one cycle");
	property p_bypassHigh;
		burstDone && burstCount < 10'h096 ##0 s_bypassHold |-> high_limit_output == output_polarity_strap;
	endproperty
	a_bypassHigh: assert property (p_bypassHigh) else $error("bypass high output not active");
	property p_bypassLow;
		burstDone && burstCount >= 10'h0FD ##0 s_bypassHold |-> low_limit_output != output_polarity_strap;
	endproperty
	a_bypassLow: assert property (p_bypassLow) else $error("bypass low output not cleared");
	property p_rdLat;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_rdLat: assert property (p_rdLat) else $error("read data late");
	property p_rdHold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_rdHold: assert property (p_rdHold) else $error("read data dropped before taken");
	property p_wrLat;
		s_wrBoth |-> ##2 s_axi_bvalid;
	endproperty
	a_wrLat: assert property (p_wrLat) else $error("write response late");
	property p_wrErr;
		s_wrBoth ##0 (s_axi_awaddr != REG_CTRL) |-> ##2 s_axi_bresp == RESP_SLVERR;
	endproperty
	a_wrErr: assert property (p_wrErr) else $error("write to read-only place not refused");
endmodule

bind lts_level_threshold lts_level_threshold_chk #(.HEALTH_CYC(HEALTH_CYC)) u_chk (
	.sys_clk(sys_clk), .rst_n(rst_n), .burstReq(burstReq), .burstDone(burstDone), .burstCount(burstCount),
	.slosh_filter_strap(slosh_filter_strap), .output_polarity_strap(output_polarity_strap),
	.low_limit_output(low_limit_output), .lowLimitOe(lowLimitOe),
	.high_limit_output(high_limit_output), .highLimitOe(highLimitOe),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata)
);

//--- verif/lts_front_end_model.sv
`timescale 1ns/1ns

module lts_front_end_model (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Burst handshake
	input wire logic burstReq,
	output logic burstDone,
	output logic [9:0] burstCount,
	// Scenario control, a zero delay loses the burst
	input wire logic [9:0] nextCount,
	input wire logic [7:0] replyDelay
);
	logic pending;
	logic [7:0] waitCnt;

	// Answers a request after the chosen delay; the count toggles outside the done pulse
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pending <= 1'b0;
			waitCnt <= 8'h00;
			burstDone <= 1'b0;
			burstCount <= 10'h155;
		end else begin
			burstDone <= 1'b0;
			burstCount <= ~burstCount;
			if (burstReq && replyDelay != 8'h00) begin
				pending <= 1'b1;
				waitCnt <= replyDelay;
			end else if (pending && waitCnt == 8'h01) begin
				pending <= 1'b0;
				burstDone <= 1'b1;
				burstCount <= nextCount;
			end else if (pending)
				waitCnt <= waitCnt - 8'h01;
		end
	end
endmodule

//--- verif/tb_lts_level_threshold.sv
`timescale 1ns/1ns

module tb_lts_level_threshold;
	import lts_pkg::*;

	localparam int unsigned CEILING = 5000;

	logic sys_clk, rst_n, burstReq, burstDone, slosh_filter_strap, output_polarity_strap;
	logic low_limit_output, lowLimitOe, high_limit_output, highLimitOe;
	logic [9:0] burstCount, nextCount;
	logic [7:0] replyDelay;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	int miscompares = 0;
	int samplesChecked = 0;
	int cycles = 0;
	int reqSeen = 0;
	int snap;
	// Counts walked across both thresholds and their bands; expected {high, low}
	logic [9:0] cntTab [7] = '{10'h0FA, 10'h095, 10'h098, 10'h099, 10'h096, 10'h0FC, 10'h0FD};
	logic [1:0] expTab [7] = '{2'h0, 2'h3, 2'h3, 2'h1, 2'h1, 2'h1, 2'h0};

	// Short counts keep the run brief
	lts_level_threshold #(.INTEG_LIMIT(4), .HEALTH_CYC(8), .BURST_GAP_CYC(20), .BURST_MAX_CYC(50)) dut (
		.sys_clk(sys_clk), .rst_n(rst_n), .burstReq(burstReq), .burstDone(burstDone), .burstCount(burstCount),
		.slosh_filter_strap(slosh_filter_strap), .output_polarity_strap(output_polarity_strap),
		.low_limit_output(low_limit_output), .lowLimitOe(lowLimitOe),
		.high_limit_output(high_limit_output), .highLimitOe(highLimitOe),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp)
	);
	lts_front_end_model u_fe (
		.sys_clk(sys_clk), .rst_n(rst_n), .burstReq(burstReq), .burstDone(burstDone),
		.burstCount(burstCount), .nextCount(nextCount), .replyDelay(replyDelay)
	);

	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	// Cycle budget and burst request tally
	always @(posedge sys_clk) begin
		cycles++;
		if (burstReq)
			reqSeen++;
		if (cycles == CEILING) begin
			miscompares++;
			results();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samplesChecked++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic results();
		$display("Checked %0d, mismatches %0d", samplesChecked, miscompares);
		if (miscompares == 0 && samplesChecked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// Address and data offered together, each released when taken
	task automatic axiWrite(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge sys_clk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		check(32'(s_axi_bresp), 32'(er));
	endtask

	// Ready raised only after the address is taken, so data must wait a cycle
	task automatic axiRead(input logic [3:0] a, output logic [31:0] d);
		@(posedge sys_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do begin
			@(posedge sys_clk);
		end while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge sys_clk);
		end while (!s_axi_rvalid);
		d = s_axi_rdata;
		check(32'(s_axi_rresp), 32'(RESP_OKAY));
		s_axi_rready <= 1'b0;
	endtask

	// One burst with the given count, then settle time for the pins
	task automatic burst(input logic [9:0] c, input int settle);
		int n;
		n = 0;
		nextCount <= c;
		// Skip a done launched at this edge, it still carries the old count
		@(posedge sys_clk);
		do begin
			@(posedge sys_clk);
			n++;
		end while (!burstDone && n < 200);
		repeat (settle) @(posedge sys_clk);
	endtask

	initial begin
		rst_n = 1'b0;
		slosh_filter_strap = 1'b0;
		output_polarity_strap = 1'b1;
		nextCount = 10'h12C;
		replyDelay = 8'h03;
		s_axi_awvalid = 1'b0;
		s_axi_awaddr = 4'h0;
		s_axi_wvalid = 1'b0;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'hF;
		s_axi_bready = 1'b0;
		s_axi_arvalid = 1'b0;
		s_axi_araddr = 4'h0;
		s_axi_rready = 1'b0;
		repeat (2) @(posedge sys_clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge sys_clk);
		check(32'({highLimitOe, lowLimitOe, high_limit_output, low_limit_output}), 32'hC);
		axiRead(REG_CTRL, rd);
		check(rd, 32'h1);
		// Bypassed filter: pins follow the decisions and their bands
		for (int i = 0; i < 7; i++) begin
			burst(cntTab[i], 3);
			check(32'({high_limit_output, low_limit_output}), 32'(expTab[i]));
		end
		repeat (4) burst(10'h12C, 3);
		slosh_filter_strap <= 1'b1;
		axiRead(REG_INTEG, rd);
		check(rd, 32'h0);
		// Filter on: outputs wait for the full count
		for (int i = 0; i < 4; i++) begin
			burst(10'h064, 4);
			check(32'({high_limit_output, low_limit_output}), (i == 3) ? 32'h3 : 32'h0);
		end
		burst(10'h064, 4);
		axiRead(REG_INTEG, rd);
		check(rd, 32'h00040004);
		repeat (2) burst(10'h0C8, 4);
		axiRead(REG_INTEG, rd);
		check(rd, 32'h00020004);
		check(32'({high_limit_output, low_limit_output}), 32'h3);
		axiRead(REG_COUNT, rd);
		check(rd, 32'h000000C8);
		slosh_filter_strap <= 1'b0;
		repeat (5) @(posedge sys_clk);
		check(32'({high_limit_output, low_limit_output}), 32'h1);
		check(32'(low_limit_output), 32'h1);
		output_polarity_strap <= 1'b0;
		repeat (3) @(posedge sys_clk);
		check(32'({high_limit_output, low_limit_output}), 32'h2);
		// Lost burst: flagged, outputs hold
		replyDelay <= 8'h00;
		repeat (120) @(posedge sys_clk);
		axiRead(REG_STATUS, rd);
		check(32'({rd[7], rd[5:4]}), 32'h4);
		check(32'({high_limit_output, low_limit_output}), 32'h2);
		// Stopped sequencer issues no further requests
		replyDelay <= 8'h03;
		axiWrite(REG_CTRL, 32'h0, RESP_OKAY);
		repeat (100) @(posedge sys_clk);
		snap = reqSeen;
		repeat (100) @(posedge sys_clk);
		check(32'(reqSeen - snap), 32'h0);
		axiRead(REG_CTRL, rd);
		check(rd, 32'h0);
		axiWrite(REG_STATUS, 32'h1, RESP_SLVERR);
		results();
	end
endmodule
